/* File: rtl/ltr_pkg.sv */
// Purpose: constants for the lockout trip and reset control block
// Assumes: one processing tick per eighth power cycle
// Notes:   time counts are in eighth-cycle ticks unless stated
package ltr_pkg;
    // ======================================================
    // scheme selection
    typedef enum logic [1:0] {
        LTR_OFF,
        LTR_SCHEME1,
        LTR_SCHEME2,
        LTR_CUSTOM
    } ltr_scheme_e;
    localparam logic [1:0] LTR_SEL_OFF    = 2'h0;
    localparam logic [1:0] LTR_SEL_S1     = 2'h1;
    localparam logic [1:0] LTR_SEL_S2     = 2'h2;
    localparam logic [1:0] LTR_SEL_CUSTOM = 2'h3;
    // ======================================================
    // widths and timing
    localparam int          LTR_MASK_W      = 8;
    localparam int          LTR_DLY_W       = 16;   // eighth-cycle ticks
    localparam logic [15:0] LTR_DLY_MAX     = 16'hFFF8; // 8191 cycles * 8
    localparam int          LTR_CUR_W       = 13;   // hundredths of an amp
    localparam logic [12:0] LTR_CUR_MIN_5A  = 13'h000A; // 0.10 A
    localparam logic [12:0] LTR_CUR_MAX_5A  = 13'h1194; // 45.00 A
    localparam logic [12:0] LTR_CUR_MIN_1A  = 13'h0002; // 0.02 A
    localparam logic [12:0] LTR_CUR_MAX_1A  = 13'h0384; // 9.00 A
    localparam int          LTR_RESET_WAIT_S  = 5;  // seconds
    localparam int          LTR_RESET_PULSE_S = 1;  // seconds
    localparam int          LTR_SAVE_HOLD_S   = 1;  // seconds
    localparam int          LTR_TICKS_PER_S   = 480; // 60 Hz eighth cycles
    localparam int          LTR_CNT_W         = 12;
    localparam logic [11:0] LTR_RESET_WAIT  = 12'(LTR_RESET_WAIT_S * LTR_TICKS_PER_S);
    localparam logic [11:0] LTR_RESET_PULSE = 12'(LTR_RESET_PULSE_S * LTR_TICKS_PER_S);
    localparam logic [11:0] LTR_SAVE_HOLD   = 12'(LTR_SAVE_HOLD_S * LTR_TICKS_PER_S);
endpackage : ltr_pkg

/* File: rtl/ltr_lockout.sv */
// Purpose: lockout trip, reset pulse and disconnect trip logic
// Assumes: tick_i is one pulse per eighth power cycle from local logic
// Notes:   trip and reset decisions step on tick_i; contact outputs pass the user assignment
`timescale 1ns/1ps
`default_nettype none
module ltr_lockout
    import ltr_pkg::*;
#(
    parameter int MASK_W = LTR_MASK_W
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic              tick_i,
    input  wire logic [MASK_W-1:0] scheme_bits_i,
    input  wire logic [MASK_W-1:0] failure_trip_mask_i,
    input  wire logic [1:0]        lockout_scheme_select_i,
    input  wire logic              custom_trip_i,
    input  wire logic              custom_reset_i,
    input  wire logic              custom_disc_i,
    input  wire logic [15:0]       isolation_delay_pickup_i,
    input  wire logic [15:0]       disconnect_open_delay_pickup_i,
    input  wire logic [12:0]       breaker_current_i,
    input  wire logic [12:0]       disconnect_current_level_i,
    input  wire logic              nominal_1a_i,
    input  wire logic              disconnect_status_in_i,
    input  wire logic              close_resistor_thermal_fail_i,
    input  wire logic              trip_resistor_thermal_fail_i,
    input  wire logic              settings_saved_i,
    input  wire logic [3:0]        output_assign_i,
    output logic                   lockout_trip_out_o,
    output logic                   lockout_reset_out_o,
    output logic                   disconnect_trip_out_o,
    output logic                   disc_alarm_out_o,
    output logic                   iso_timed_out_o,
    output logic                   open_timed_out_o
);
    // refuse mask widths the reduction logic is not meant for
    if (MASK_W < 1 || MASK_W > 64) begin : g_bad_mask_w
        $error("MASK_W out of range");
    end

    // ======================================================
    // state
    typedef struct packed {
        logic        trip;
        logic        rst_out;
        logic        disc;
        logic        alarm;
        logic [15:0] iso_cnt;
        logic [15:0] open_cnt;
        logic [11:0] rst_cnt;
        logic [11:0] pulse_cnt;
        logic [11:0] save_cnt;
        logic        rst_done;
        logic        o_trip;
        logic        o_rst;
        logic        o_disc;
        logic        o_alarm;
        logic        o_iso;
        logic        o_open;
    } ltr_state_s;

    ltr_state_s st;
    ltr_state_s next_st;

    // threshold clamp to the rating's legal range
    function automatic logic [12:0] ltr_clamp(input logic [12:0] v, input logic one_a);
        logic [12:0] lo;
        logic [12:0] hi;
        lo = one_a ? LTR_CUR_MIN_1A : LTR_CUR_MIN_5A;
        hi = one_a ? LTR_CUR_MAX_1A : LTR_CUR_MAX_5A;
        if (v < lo) return lo;
        if (v > hi) return hi;
        return v;
    endfunction : ltr_clamp

    // delay pickup clamp to 8191 cycles
    function automatic logic [15:0] ltr_dly(input logic [15:0] v);
        return (v > LTR_DLY_MAX) ? LTR_DLY_MAX : v;
    endfunction : ltr_dly

    logic [12:0] thr;
    logic        cur_on;
    logic        cond;
    logic        s1;
    logic        s2;
    logic        cus;
    logic        iso_done;
    logic        open_done;
    logic        thermal;

    // ======================================================
    // next-state logic
    always_comb begin
        next_st   = st;
        thr       = ltr_clamp(disconnect_current_level_i, nominal_1a_i);
        cur_on    = breaker_current_i >= thr;
        cond      = |(scheme_bits_i & failure_trip_mask_i);
        s1        = lockout_scheme_select_i == LTR_SEL_S1;
        s2        = lockout_scheme_select_i == LTR_SEL_S2;
        cus       = lockout_scheme_select_i == LTR_SEL_CUSTOM;
        iso_done  = st.iso_cnt >= ltr_dly(isolation_delay_pickup_i);
        open_done = st.open_cnt >= ltr_dly(disconnect_open_delay_pickup_i);
        thermal   = close_resistor_thermal_fail_i | trip_resistor_thermal_fail_i;
        if (tick_i) begin
            if (cus) begin
                next_st.trip    = custom_trip_i;
                next_st.rst_out = custom_reset_i;
                next_st.disc    = custom_disc_i;
                next_st.alarm   = 1'b0;
            end else if (!(s1 || s2)) begin
                next_st.trip     = 1'b0;
                next_st.rst_out  = 1'b0;
                next_st.disc     = 1'b0;
                next_st.alarm    = 1'b0;
                next_st.iso_cnt  = '0;
                next_st.open_cnt = '0;
                next_st.rst_cnt  = '0;
            end else begin
                // trip latch and isolation timer
                if (cond) begin
                    next_st.trip     = 1'b1;
                    next_st.iso_cnt  = '0;
                    next_st.open_cnt = '0;
                    next_st.disc     = 1'b0;
                    next_st.rst_done = 1'b0;
                end else if (st.trip) begin
                    if (!iso_done && (s1 || !cur_on))
                        next_st.iso_cnt = st.iso_cnt + 16'h0001;
                    if (s2 && !cur_on && !iso_done) next_st.iso_cnt = st.iso_cnt + 16'h0001;
                    if (s1 && iso_done) next_st.trip = 1'b0;
                    if (s2 && iso_done && !cur_on) next_st.disc = 1'b1;
                    // open delay runs from the disconnect trip on, whatever the current
                    if (s2 && st.disc) begin
                        if (!open_done) begin
                            next_st.open_cnt = st.open_cnt + 16'h0001;
                        end else if (!disconnect_status_in_i || !cur_on) begin
                            next_st.trip = 1'b0;
                        end
                    end
                end
                // current after disconnect trip alarm
                next_st.alarm = s2 && st.disc && open_done && cur_on
                                && disconnect_status_in_i;
                // reset wait and pulse
                if (cond || st.trip || cur_on || thermal || st.rst_done) begin
                    next_st.rst_cnt = '0;
                end else if (st.rst_cnt < LTR_RESET_WAIT) begin
                    next_st.rst_cnt = st.rst_cnt + 12'h001;
                end else if (!st.rst_out) begin
                    next_st.rst_out   = 1'b1;
                    next_st.pulse_cnt = '0;
                end
                if (st.rst_out) begin
                    next_st.pulse_cnt = st.pulse_cnt + 12'h001;
                    if (thermal || st.pulse_cnt >= LTR_RESET_PULSE - 12'h001) begin
                        next_st.rst_out  = 1'b0;
                        next_st.disc     = 1'b0;
                        next_st.rst_done = 1'b1;
                        next_st.rst_cnt  = '0;
                    end
                end
            end
            if (st.save_cnt != '0) next_st.save_cnt = st.save_cnt - 12'h001;
        end
        if (settings_saved_i) next_st.save_cnt = LTR_SAVE_HOLD;
        // contacts follow assignment, blanked while saving
        next_st.o_trip  = (st.save_cnt == '0) && output_assign_i[0] && st.trip;
        next_st.o_rst   = (st.save_cnt == '0) && output_assign_i[1] && st.rst_out;
        next_st.o_disc  = (st.save_cnt == '0) && output_assign_i[2] && st.disc;
        next_st.o_alarm = (st.save_cnt == '0) && output_assign_i[3] && st.alarm;
        // status bits read one while timed out and the trip (iso) or disconnect trip (open) is still held
        next_st.o_iso   = st.trip && iso_done;
        next_st.o_open  = st.disc && open_done;
    end

    // ======================================================
    // state register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lockout_trip_out_o    = st.o_trip;
    assign lockout_reset_out_o   = st.o_rst;
    assign disconnect_trip_out_o = st.o_disc;
    assign disc_alarm_out_o      = st.o_alarm;
    assign iso_timed_out_o       = st.o_iso;
    assign open_timed_out_o      = st.o_open;

    // ======================================================
    // checks
    AST_MASK_TRIP: assert property (@(posedge mclk_i) disable iff (reset_i)
        tick_i && (s1 || s2) && cond |=> st.trip)
        else $error("masked trip not latched");
    AST_SAVE_BLANK: assert property (@(posedge mclk_i) disable iff (reset_i)
        settings_saved_i |=> ##1 !lockout_trip_out_o)
        else $error("output not blanked after save");
    AST_NO_ASSIGN: assert property (@(posedge mclk_i) disable iff (reset_i)
        !output_assign_i[0] |=> !lockout_trip_out_o)
        else $error("unassigned trip drove contact");
    AST_RST_CUR: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(st.rst_out) && !cus |-> $past(!cur_on))
        else $error("reset with current flowing");
    AST_RST_THERM: assert property (@(posedge mclk_i) disable iff (reset_i)
        thermal && tick_i && !cus |=> !$rose(st.rst_out))
        else $error("reset during thermal fail");
    AST_S1_NODISC: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1 && tick_i |=> !$rose(st.disc))
        else $error("disconnect trip in scheme 1");
    AST_S1_REL: assert property (@(posedge mclk_i) disable iff (reset_i)
        s1 && $fell(st.trip) |-> $past(iso_done))
        else $error("early trip release");
    AST_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
        lockout_scheme_select_i == LTR_SEL_OFF && tick_i |=> !st.trip)
        else $error("trip while off");
    COV_TRIP: cover property (@(posedge mclk_i) $rose(st.trip));
    COV_RST: cover property (@(posedge mclk_i) $rose(st.rst_out));
    COV_DISC: cover property (@(posedge mclk_i) $rose(st.disc));
    COV_ALARM: cover property (@(posedge mclk_i) $rose(st.alarm));
endmodule : ltr_lockout
`default_nettype wire

/* File: verif/ltr_disc_model.sv */
// Purpose: behavioural disconnect on the far side of the disconnect trip
// Assumes: opening takes OPEN_CYC clocks after a trip command
// Notes:   stuck_i keeps the disconnect closed to mimic a slow unit
`timescale 1ns/1ps
`default_nettype none
module ltr_disc_model #(
    parameter int OPEN_CYC = 8
) (
    input  wire logic mclk_i,
    input  wire logic reset_i,
    input  wire logic disc_trip_i,
    input  wire logic stuck_i,
    output logic      disc_closed_o
);
    // ======================================================
    // travel of the disconnect blades
    int run;
    // count travel while commanded, reclose once the command drops
    always_ff @(posedge mclk_i) begin
        if (reset_i || !disc_trip_i) begin
            run <= 0;
        end else if (run < OPEN_CYC) begin
            run <= run + 1;
        end
    end
    // status high while closed; a stuck unit never opens
    assign disc_closed_o = stuck_i || (run < OPEN_CYC);
endmodule : ltr_disc_model
`default_nettype wire

/* File: verif/ltr_lockout_test.sv */
// Purpose: self-checking bench for the lockout trip and reset block
// Assumes: one tick per clock; short isolation and open delays
// Notes:   random masks and scheme bits among fixed corner cases
`timescale 1ns/1ps
`default_nettype none
module ltr_lockout_test
    import ltr_pkg::*;
;
    // ======================================================
    // stimulus and observed signals
    logic        mclk_i = 1'b0, reset_i = 1'b1, sav = 1'b0, stuck = 1'b0, ct = 1'b1, n1a = 1'b0;
    logic [7:0]  sb = 8'h00, mk = 8'h00;
    logic [1:0]  sel = LTR_SEL_S1, thf = 2'h0;
    logic [3:0]  asg = 4'hF, outs;
    logic [12:0] cur = 13'h0000;
    logic        dst, trip, rst, disc, alrm, isot, opnt, tck = 1'b1;
    int          error_cnt = 0, n_compared = 0, n, k;
    assign outs = {alrm, disc, rst, trip};
    // clock and watchdog
    initial forever #10 mclk_i = ~mclk_i;
    initial begin
        step(40000);
        error_cnt++;
        final_report();
    end
    ltr_lockout i_ltr_lockout (
        .mclk_i(mclk_i), .reset_i(reset_i), .tick_i(tck), .scheme_bits_i(sb),
        .failure_trip_mask_i(mk), .lockout_scheme_select_i(sel), .custom_trip_i(ct),
        // short isolation delay for run time; field setting is far longer
        .custom_reset_i(ct), .custom_disc_i(ct), .isolation_delay_pickup_i(16'h0040),
        .disconnect_open_delay_pickup_i(16'h0010), .breaker_current_i(cur),
        .disconnect_current_level_i(13'h0064), .nominal_1a_i(n1a),
        .disconnect_status_in_i(dst), .close_resistor_thermal_fail_i(thf[1]),
        .trip_resistor_thermal_fail_i(thf[0]), .settings_saved_i(sav), .output_assign_i(asg),
        .lockout_trip_out_o(trip), .lockout_reset_out_o(rst), .disconnect_trip_out_o(disc),
        .disc_alarm_out_o(alrm), .iso_timed_out_o(isot), .open_timed_out_o(opnt));
    ltr_disc_model i_ltr_disc_model (.mclk_i(mclk_i), .reset_i(reset_i),
        .disc_trip_i(disc), .stuck_i(stuck), .disc_closed_o(dst));
    // ======================================================
    // shared tasks
    task automatic step(input int c);
        repeat (c) @(posedge mclk_i);
    endtask : step
    task automatic chk(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : chk
    // wait up to lim clocks for output j to reach v, n counts clocks
    task automatic waitv(input int j, input logic v, input int lim);
        n = 0;
        while (outs[j] !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask : waitv
    task automatic fire();
        sb <= mk;
        step(3);
        chk(trip, 1'b1, "trip not raised");
        sb <= 8'h00;
    endtask : fire
    task automatic restart(input int c);
        reset_i <= 1'b1;
        step(c);
        reset_i <= 1'b0;
    endtask : restart
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // ======================================================
    // scenarios
    initial begin
        k = $urandom(32'h0A68);
        n1a <= 1'($urandom);
        restart(6);
        step(2);
        chk(|outs, 1'b0, "outputs not clear after reset");
        // no decision without a processing tick
        tck <= 1'b0;
        mk  <= 8'h80;
        sb  <= 8'h80;
        step(4);
        chk(trip, 1'b0, "trip without tick");
        tck <= 1'b1;
        step(3);
        chk(trip, 1'b1, "trip missing on tick");
        sb <= 8'h00;
        waitv(0, 1'b0, 200);
        // excluded failure bits leave the trip alone
        repeat (20) begin
            k = $urandom;
            mk <= 8'(k);
            sb <= 8'($urandom) & ~8'(k);
            step(3);
            chk(trip, 1'b0, "trip from excluded bit");
        end
        mk <= 8'h01 << ($urandom % 8);
        sb <= 8'h00;
        step(1);
        fire();
        chk(isot, 1'b0, "isolation timed out early");
        asg <= 4'hE;
        step(3);
        chk(trip, 1'b0, "unassigned trip driven");
        asg <= 4'hF;
        step(3);
        chk(trip, 1'b1, "trip released before delay");
        waitv(0, 1'b0, 200);
        chk(trip, 1'b0, "trip never released");
        waitv(1, 1'b1, 3000);
        chk(n >= int'(LTR_RESET_WAIT) - 90 && n <= int'(LTR_RESET_WAIT) + 6, 1'b1, "reset wait");
        waitv(1, 1'b0, 600);
        chk(n >= int'(LTR_RESET_PULSE) - 2 && n <= int'(LTR_RESET_PULSE) + 2, 1'b1, "pulse");
        fire();
        thf <= 2'($urandom % 3 + 1);
        waitv(1, 1'b1, 3000);
        chk(rst, 1'b0, "reset despite thermal fail");
        fire();
        thf <= 2'h0;
        cur <= 13'h01F4;
        waitv(1, 1'b1, 3000);
        chk(rst, 1'b0, "reset with current flowing");
        cur <= 13'h0000;
        waitv(1, 1'b1, 3000);
        chk(rst, 1'b1, "reset missing after current drop");
        waitv(1, 1'b0, 600);
        // hold the trip request through the whole blanking time
        sb <= mk;
        sav <= 1'b1;
        step(1);
        sav <= 1'b0;
        step(3);
        chk(trip, 1'b0, "trip not blanked on save");
        step(int'(LTR_SAVE_HOLD) - 2);
        chk(trip, 1'b0, "blanking too short");
        step(1);
        chk(trip, 1'b1, "blanking too long");
        for (k = 1; k < 4; k++) begin
            sel <= LTR_SEL_OFF;
            sb <= mk;
            step(4);
            chk(trip, 1'b0, "trip in off mode");
            sel <= 2'(k);
            step(3);
            chk(trip, 1'b1, "no trip in active mode");
        end
        sb <= 8'h00;
        restart(2);
        sel <= LTR_SEL_S2;
        cur <= 13'h01F4;
        fire();
        step(100);
        chk(disc, 1'b0, "disconnect trip with current");
        cur <= 13'h0000;
        waitv(2, 1'b1, 100);
        chk(disc, 1'b1, "no disconnect trip");
        chk(opnt, 1'b0, "open delay timed out early");
        chk(isot, 1'b1, "isolation not timed out");
        chk(trip, 1'b1, "trip released with disconnect trip");
        waitv(0, 1'b0, 100);
        chk(n >= 14 && n < 100, 1'b1, "open delay not kept");
        chk(opnt, 1'b1, "open delay not timed out");
        restart(2);
        stuck <= 1'b1;
        cur <= 13'h01F4;
        fire();
        step(100);
        cur <= 13'h0000;
        waitv(2, 1'b1, 100);
        cur <= 13'h01F4;
        waitv(3, 1'b1, 200);
        chk(alrm, 1'b1, "no alarm for slow disconnect");
        final_report();
    end
endmodule : ltr_lockout_test
`default_nettype wire
